//--- design/tpw_pkg.sv
// constants, field layouts and types of the pwm waveform timer
package tpw_pkg;
  // waveform mode select codes handled here
  localparam logic [2:0] WGM_PC_FIXED = 3'h1;
  localparam logic [2:0] WGM_FAST_FIXED = 3'h3;
  localparam logic [2:0] WGM_PC_VAR = 3'h5;
  localparam logic [2:0] WGM_FAST_VAR = 3'h7;
  // compare output mode codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;
  // counter landmarks
  localparam logic [7:0] TOP_FIXED = 8'hff;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] CNT_STEP = 8'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // register addresses
  localparam logic [2:0] ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] ADDR_COUNT = 3'h2;
  localparam logic [2:0] ADDR_CMP_A = 3'h3;
  localparam logic [2:0] ADDR_CMP_B = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;
  // control A fields
  localparam int CA_COMA_HI = 7;
  localparam int CA_COMA_LO = 6;
  localparam int CA_COMB_HI = 5;
  localparam int CA_COMB_LO = 4;
  localparam int CA_WGM_HI = 1;
  // control B fields
  localparam int CB_WGM_HIBIT = 3;
  localparam int CB_CS_HI = 2;
  // flag bit positions
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int NUM_CH = 2;
  // prescaler clock selects and divider masks
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV64 = 10'h03f;
  localparam logic [9:0] MASK_DIV256 = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
  localparam logic [9:0] DIV_ZERO = 10'h000;
  localparam logic [9:0] DIV_STEP = 10'h001;
  // count direction of the dual-slope counter
  typedef enum logic {TPW_UP, TPW_DOWN} tpw_dir_t;
endpackage : tpw_pkg

//--- design/tpw_prescaler.sv
// prescaler that turns the i/o clock into a one-cycle timer tick
`timescale 1ns/100ps
`default_nettype none
module tpw_prescaler
  import tpw_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] clkSel,
  output logic tickQ
);
  logic [9:0] divQ;
  logic [9:0] mask;

  // divider mask per selection; unknown selects stop the timer
  always_comb begin
    unique case (clkSel)
      CS_DIV8: mask = MASK_DIV8;
      CS_DIV64: mask = MASK_DIV64;
      CS_DIV256: mask = MASK_DIV256;
      CS_DIV1024: mask = MASK_DIV1024;
      default: mask = DIV_ZERO;
    endcase
  end

  // free divider, held at zero while stopped so restarts are aligned
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divQ <= DIV_ZERO;
    end else if (clkSel == CS_STOP) begin
      divQ <= DIV_ZERO;
    end else begin
      divQ <= divQ + DIV_STEP;
    end
  end

  // tick is a clock enable only, never a clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tickQ <= 1'b0;
    end else begin
      tickQ <= (clkSel == CS_DIV1) ||
               ((mask != DIV_ZERO) && ((divQ & mask) == mask));
    end
  end

  AST_TICK_DIV1: assert property (@(posedge clk) disable iff (!arst_n)
    clkSel == CS_DIV1 |=> tickQ)
    else $error("undivided select gave no tick");
  AST_TICK_DIV8: assert property (@(posedge clk) disable iff (!arst_n)
    (clkSel == CS_DIV8) [*8] |-> ##[1:1] $past(tickQ, 1) || tickQ ||
    $past(tickQ, 2) || $past(tickQ, 3) || $past(tickQ, 4) ||
    $past(tickQ, 5) || $past(tickQ, 6) || $past(tickQ, 7))
    else $error("divide by eight produced no tick in eight cycles");
endmodule : tpw_prescaler
`default_nettype wire

//--- design/tpw_timer_pwm.sv
// 8-bit timer counter with fast and phase-correct pwm waveform generation
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - waveform mode 3 or 7 runs fast single-slope pwm counting zero to top.
// - fast pwm top is 0xff in mode 3, compare value a in mode 7.
// - fast pwm counts up to top, then clears to zero next tick.
// - fast pwm non-inverting clears on match, sets at zero; inverting opposite.
// - fast pwm bottom update happens in the tick that wraps top to zero.
// - fast pwm output mode two is non-inverted, three is inverted.
// - fast pwm mode one with high mode bit toggles output a only.
// - fast and phase-correct pwm double-buffer compare values; other modes apply them directly.
// - fast pwm sets the overflow flag each time the counter reaches top.
// - fast pwm compare zero gives one-tick spike, compare top constant level.
// - waveform mode 1 or 5 runs dual-slope phase-correct pwm.
// - phase-correct top is 0xff in mode 1, compare value a in mode 5.
// - phase-correct counter holds top exactly one tick then counts down.
// - non-inverting clears on up match, sets on down match; inverting opposite.
// - phase-correct output mode two is non-inverted, three is inverted.
// - phase-correct mode one with high mode bit toggles output a only.
// - phase-correct sets the overflow flag each time the counter reaches zero.
// - phase-correct compare zero gives constant low, top constant high, non-inverted.
// - phase-correct output at top equals the up-match result for symmetry, except with compare at top.
// - a missed up match is still corrected without a compare match.
// - fully synchronous; the timer tick is only a clock enable.
// - timer tick divides the clock by 1, 8, 64, 256 or 1024.
// - output mode zero disconnects the waveform from the pin in every mode.
// - fast pwm with compare at top ignores the match, acts at zero.
// - phase-correct with compare at top ignores the match, acts at top.
module tpw_timer_pwm
  import tpw_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdDataQ,
  output logic waveOutA,
  output logic waveEnA,
  output logic waveOutB,
  output logic waveEnB,
  output logic overflowFlag,
  output logic compareFlagA,
  output logic compareFlagB
);
  logic [7:0] ctrlAQ;
  logic [3:0] ctrlBQ;
  logic [7:0] counterValueQ;
  tpw_dir_t dirQ;
  logic [2:0] flagsQ;
  logic [7:0] cmpBufQ [NUM_CH];
  logic [7:0] cmpActQ [NUM_CH];
  logic [1:0] comMode [NUM_CH];
  logic [NUM_CH-1:0] waveQ;
  logic [NUM_CH-1:0] waveEnQ;
  logic [NUM_CH-1:0] cmpMatch;
  logic timerTick;
  logic [2:0] waveformModeSelect;
  logic modeSelectHighBit;
  logic fastMode;
  logic pcMode;
  logic [7:0] topValue;
  logic atTop;
  logic atBottom;
  logic upNow;
  logic cntWr;
  logic ovfSet;
  logic [2:0] flagSet;
  logic [2:0] flagClr;
  logic [7:0] rdMux;

  // mode decode
  assign modeSelectHighBit = ctrlBQ[CB_WGM_HIBIT];
  assign waveformModeSelect = {modeSelectHighBit, ctrlAQ[CA_WGM_HI:0]};
  assign fastMode = (waveformModeSelect == WGM_FAST_FIXED) ||
                    (waveformModeSelect == WGM_FAST_VAR);
  assign pcMode = (waveformModeSelect == WGM_PC_FIXED) ||
                  (waveformModeSelect == WGM_PC_VAR);
  // top from the active (already buffered) compare a value
  assign topValue = modeSelectHighBit ? cmpActQ[0] : TOP_FIXED;
  assign atTop = (counterValueQ == topValue);
  assign atBottom = (counterValueQ == BOTTOM);
  assign cntWr = regWrEn && (regAddr == ADDR_COUNT);
  assign comMode[0] = ctrlAQ[CA_COMA_HI:CA_COMA_LO];
  assign comMode[1] = ctrlAQ[CA_COMB_HI:CA_COMB_LO];

  // direction the counter moves in at this tick; bottom always counts as up
  always_comb begin
    unique case (dirQ)
      TPW_UP: upNow = !atTop || atBottom;
      TPW_DOWN: upNow = atBottom;
    endcase
  end

  // tick source
  tpw_prescaler uPrescaler (
    .clk(clk),
    .arst_n(arst_n),
    .clkSel(ctrlBQ[CB_CS_HI:0]),
    .tickQ(timerTick)
  );

  // control registers; output mode changes act at once, no buffering
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlAQ <= RST_BYTE;
      ctrlBQ <= RST_BYTE[3:0];
    end else if (regWrEn) begin
      if (regAddr == ADDR_CTRL_A) begin
        ctrlAQ <= regWrData;
      end
      if (regAddr == ADDR_CTRL_B) begin
        ctrlBQ <= regWrData[3:0];
      end
    end
  end

  // counter; a software write wins over the tick
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      counterValueQ <= BOTTOM;
    end else if (cntWr) begin
      counterValueQ <= regWrData;
    end else if (timerTick) begin
      if (fastMode) begin
        counterValueQ <= atTop ? BOTTOM : counterValueQ + CNT_STEP;
      end else if (pcMode) begin
        unique case (dirQ)
          TPW_UP: begin
            // top is held for one tick by turning round here
            if (atTop) begin
              counterValueQ <= atBottom ? BOTTOM : counterValueQ - CNT_STEP;
            end else begin
              counterValueQ <= counterValueQ + CNT_STEP;
            end
          end
          TPW_DOWN: begin
            if (atBottom) begin
              counterValueQ <= atTop ? BOTTOM : counterValueQ + CNT_STEP;
            end else begin
              counterValueQ <= counterValueQ - CNT_STEP;
            end
          end
        endcase
      end else begin
        // modes outside pwm just run free
        counterValueQ <= counterValueQ + CNT_STEP;
      end
    end
  end

  // count direction of the dual slope
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dirQ <= TPW_UP;
    end else if (!pcMode) begin
      dirQ <= TPW_UP;
    end else if (timerTick && !cntWr) begin
      unique case (dirQ)
        TPW_UP: if (atTop && !atBottom) dirQ <= TPW_DOWN;
        TPW_DOWN: if (atBottom) dirQ <= TPW_UP;
      endcase
    end
  end

  // per channel compare buffer, active value and waveform unit
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : gChan
    logic [2:0] bufAddr;
    assign bufAddr = (ch == 0) ? ADDR_CMP_A : ADDR_CMP_B;
    assign cmpMatch[ch] = timerTick && (counterValueQ == cmpActQ[ch]);

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cmpBufQ[ch] <= RST_BYTE;
      end else if (regWrEn && (regAddr == bufAddr)) begin
        cmpBufQ[ch] <= regWrData;
      end
    end

    // pwm transfers at top so a period never sees a half-changed duty
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cmpActQ[ch] <= RST_BYTE;
      end else if (!(fastMode || pcMode)) begin
        cmpActQ[ch] <= cmpBufQ[ch];
      end else if (timerTick && atTop) begin
        cmpActQ[ch] <= cmpBufQ[ch];
      end
    end

    tpw_wave_channel #(
      .TOGGLE_OK(ch == 0)
    ) uWave (
      .clk(clk),
      .arst_n(arst_n),
      .tick(timerTick),
      .fastMode(fastMode),
      .pcMode(pcMode),
      .modeSelectHighBit(modeSelectHighBit),
      .upNow(upNow),
      .counterValue(counterValueQ),
      .topValue(topValue),
      .compareValue(cmpActQ[ch]),
      .compareOutputMode(comMode[ch]),
      .waveQ(waveQ[ch]),
      .waveEnQ(waveEnQ[ch])
    );

    // the active compare value moves only at top while a pwm mode runs
    AST_BUF_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      (fastMode || pcMode) && !(timerTick && atTop) |=>
      $stable(cmpActQ[ch]))
      else $error("active compare value changed away from top");

    // a fast pwm match below top gives the match level
    AST_FAST_MATCH: assert property (@(posedge clk) disable iff (!arst_n)
      fastMode && timerTick && !atTop && comMode[ch][1] &&
      counterValueQ == cmpActQ[ch] |=> waveQ[ch] == $past(comMode[ch][0]))
      else $error("fast pwm match gave wrong level");

    // a down-counting match lands on the opposite level of an up match
    AST_PC_DOWNMATCH: assert property (@(posedge clk) disable iff (!arst_n)
      pcMode && timerTick && comMode[ch][1] && dirQ == TPW_DOWN && !atBottom && !atTop &&
      counterValueQ == cmpActQ[ch] |=>
      waveQ[ch] == !$past(comMode[ch][0]))
      else $error("down-counting match gave wrong level");

    // leaving top, or a missed up match, still ends at the up-match level
    AST_PC_TOP_MISS: assert property (@(posedge clk) disable iff (!arst_n)
      pcMode && timerTick && atTop && comMode[ch][1] && cmpActQ[ch] != topValue |=>
      waveQ[ch] == $past(comMode[ch][0]))
      else $error("phase correct top level not the up-match level");
  end

  assign waveOutA = waveQ[0];
  assign waveEnA = waveEnQ[0];
  assign waveOutB = waveQ[1];
  assign waveEnB = waveEnQ[1];

  // overflow moment depends on the family
  always_comb begin
    if (fastMode) begin
      ovfSet = timerTick && atTop;
    end else if (pcMode) begin
      ovfSet = timerTick && atBottom && (dirQ == TPW_DOWN);
    end else begin
      ovfSet = timerTick && (counterValueQ == TOP_FIXED);
    end
  end

  assign flagSet = {cmpMatch[1], cmpMatch[0], ovfSet};
  assign flagClr = (regWrEn && (regAddr == ADDR_FLAGS)) ? regWrData[2:0] : 3'h0;

  // sticky flags, write one to clear; a set in the clear cycle survives
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flagsQ <= 3'h0;
    end else begin
      flagsQ <= (flagsQ & ~flagClr) | flagSet;
    end
  end

  assign overflowFlag = flagsQ[FLG_OVF];
  assign compareFlagA = flagsQ[FLG_CMPA];
  assign compareFlagB = flagsQ[FLG_CMPB];

  // read mux; compare addresses return the software-written buffer
  always_comb begin
    unique case (regAddr)
      ADDR_CTRL_A: rdMux = ctrlAQ;
      ADDR_CTRL_B: rdMux = {4'h0, ctrlBQ};
      ADDR_COUNT: rdMux = counterValueQ;
      ADDR_CMP_A: rdMux = cmpBufQ[0];
      ADDR_CMP_B: rdMux = cmpBufQ[1];
      ADDR_FLAGS: rdMux = {5'h00, flagsQ};
      default: rdMux = RST_BYTE;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdDataQ <= RST_BYTE;
    end else begin
      regRdDataQ <= regRdEn ? rdMux : RST_BYTE;
    end
  end

  AST_FAST_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
    fastMode && timerTick && atTop && !cntWr |=> counterValueQ == BOTTOM)
    else $error("fast pwm did not clear after top");
  AST_FAST_INC: assert property (@(posedge clk) disable iff (!arst_n)
    fastMode && timerTick && !atTop && !cntWr |=>
    counterValueQ == 8'($past(counterValueQ) + CNT_STEP))
    else $error("fast pwm did not increment");
  AST_CNT_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    !timerTick && !cntWr |=> $stable(counterValueQ))
    else $error("counter moved without a tick");
  AST_OVF_FAST: assert property (@(posedge clk) disable iff (!arst_n)
    fastMode && timerTick && atTop |=> overflowFlag)
    else $error("overflow flag not set at top");
  AST_OVF_PC: assert property (@(posedge clk) disable iff (!arst_n)
    pcMode && timerTick && atBottom && dirQ == TPW_DOWN |=> overflowFlag)
    else $error("overflow flag not set at bottom");
  AST_PC_TURN: assert property (@(posedge clk) disable iff (!arst_n)
    pcMode && timerTick && atTop && !atBottom && dirQ == TPW_UP && !cntWr |=>
    counterValueQ == 8'($past(topValue) - CNT_STEP) && dirQ == TPW_DOWN)
    else $error("phase correct did not turn at top");
  AST_BUF_XFER: assert property (@(posedge clk) disable iff (!arst_n)
    (fastMode || pcMode) && timerTick && atTop |=> cmpActQ[1] == $past(cmpBufQ[1]))
    else $error("compare buffer not transferred at top");

  // channel b has no toggle: the reserved code leaves pin and register alone
  AST_TOG_B: assert property (@(posedge clk) disable iff (!arst_n)
    (fastMode || pcMode) && comMode[1] == COM_TOGGLE |=>
    !waveEnB && $stable(waveOutB))
    else $error("channel b reacted to the toggle code in pwm");

  // dual-slope counting between the turning points
  AST_PC_UP: assert property (@(posedge clk) disable iff (!arst_n)
    pcMode && timerTick && dirQ == TPW_UP && !atTop && !cntWr |=>
    counterValueQ == 8'($past(counterValueQ) + CNT_STEP))
    else $error("phase correct did not count up");
  AST_PC_DOWN: assert property (@(posedge clk) disable iff (!arst_n)
    pcMode && timerTick && dirQ == TPW_DOWN && !atBottom && !cntWr |=>
    counterValueQ == 8'($past(counterValueQ) - CNT_STEP))
    else $error("phase correct did not count down");
  AST_PC_BOTTOM: assert property (@(posedge clk) disable iff (!arst_n)
    pcMode && timerTick && dirQ == TPW_DOWN && atBottom && !atTop && !cntWr |=>
    counterValueQ == 8'(BOTTOM + CNT_STEP) && dirQ == TPW_UP)
    else $error("phase correct did not turn at bottom");

  // overflow must stay quiet away from its landmark, a stray set would fake a period
  AST_OVF_FAST_ONLY: assert property (@(posedge clk) disable iff (!arst_n)
    fastMode && !overflowFlag && !(timerTick && atTop) |=> !overflowFlag)
    else $error("fast pwm overflow set away from top");
  AST_OVF_PC_ONLY: assert property (@(posedge clk) disable iff (!arst_n)
    pcMode && !overflowFlag && !(timerTick && atBottom) |=> !overflowFlag)
    else $error("phase correct overflow set away from bottom");
endmodule : tpw_timer_pwm
`default_nettype wire

//--- design/tpw_wave_channel.sv
// one compare output channel: waveform register and pin override
`timescale 1ns/100ps
`default_nettype none
module tpw_wave_channel
  import tpw_pkg::*;
#(
  parameter logic TOGGLE_OK = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic fastMode,
  input wire logic pcMode,
  input wire logic modeSelectHighBit,
  input wire logic upNow,
  input wire logic [7:0] counterValue,
  input wire logic [7:0] topValue,
  input wire logic [7:0] compareValue,
  input wire logic [1:0] compareOutputMode,
  output logic waveQ,
  output logic waveEnQ
);
  logic atTop;
  logic match;
  logic cmpIsTop;
  logic inv;
  logic pwmOn;
  logic togOn;

  assign atTop = (counterValue == topValue);
  assign match = (counterValue == compareValue);
  assign cmpIsTop = (compareValue == topValue);
  assign inv = compareOutputMode[0];
  assign pwmOn = compareOutputMode[1];
  assign togOn = (compareOutputMode == COM_TOGGLE) && TOGGLE_OK && modeSelectHighBit;

  // waveform register; the top/bottom action outranks a match at top
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waveQ <= 1'b0;
    end else if (tick && fastMode) begin
      if (pwmOn) begin
        if (atTop) begin
          waveQ <= !inv;
        end else if (match) begin
          waveQ <= inv;
        end
      end else if (togOn && match) begin
        waveQ <= !waveQ;
      end
    end else if (tick && pcMode) begin
      if (pwmOn) begin
        if (atTop) begin
          // at top the up-match result is forced unless compare is top, repairing missed matches
          waveQ <= cmpIsTop ? !inv : inv;
        end else if (match) begin
          waveQ <= upNow ? inv : !inv;
        end
      end else if (togOn && match) begin
        waveQ <= !waveQ;
      end
    end
  end

  // pin override; reserved toggle codes in pwm modes leave the pin alone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waveEnQ <= 1'b0;
    end else begin
      waveEnQ <= (compareOutputMode != COM_OFF) &&
                 !((compareOutputMode == COM_TOGGLE) && (fastMode || pcMode) && !togOn);
    end
  end

  AST_DISCONNECT: assert property (@(posedge clk) disable iff (!arst_n)
    compareOutputMode == COM_OFF |=> !waveEnQ)
    else $error("pin driven with compare output mode zero");
  AST_FAST_BOTTOM: assert property (@(posedge clk) disable iff (!arst_n)
    tick && fastMode && pwmOn && atTop |=> waveQ == !$past(inv))
    else $error("fast pwm bottom update missing at wrap");
  AST_PC_TOP: assert property (@(posedge clk) disable iff (!arst_n)
    tick && pcMode && pwmOn && atTop && cmpIsTop |=> waveQ == !$past(inv))
    else $error("phase correct top level wrong with compare at top");
  AST_PC_UPMATCH: assert property (@(posedge clk) disable iff (!arst_n)
    tick && pcMode && pwmOn && !atTop && match && upNow |=> waveQ == $past(inv))
    else $error("up-counting match gave wrong level");
endmodule : tpw_wave_channel
`default_nettype wire

//--- testbench/tpw_load_model.sv
// load model: tallies high time seen on both pwm pins
`timescale 1ns/100ps
`default_nettype none
module tpw_load_model (
  input wire logic clk,
  input wire logic pinA,
  input wire logic pinB,
  input wire logic clr,
  output logic [19:0] hiA,
  output logic [19:0] hiB
);
  // a clear restarts both tallies so that each window stands alone
  always_ff @(posedge clk) begin
    hiA <= clr ? 20'h0 : hiA + {19'h0, pinA};
    hiB <= clr ? 20'h0 : hiB + {19'h0, pinB};
  end
endmodule : tpw_load_model
`default_nettype wire

//--- testbench/tpw_timer_pwm_tb_top.sv
// self-checking bench for the pwm waveform timer
`timescale 1ns/100ps
`default_nettype none
module tpw_timer_pwm_tb_top;
  import tpw_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdDataQ;
  logic waveOutA, waveEnA, waveOutB, waveEnB;
  logic overflowFlag, compareFlagA, compareFlagB;
  logic clr = 1'b0;
  logic rdPend = 1'b0;
  logic [19:0] hiA, hiB;
  logic [7:0] expQ[$];
  logic [31:0] seed = 32'h2ece;
  int error_cnt = 0;
  int n_tests = 0;

  // 10 MHz i/o clock
  always #50 clk = ~clk;

  tpw_timer_pwm dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdDataQ(regRdDataQ), .waveOutA(waveOutA),
    .waveEnA(waveEnA), .waveOutB(waveOutB), .waveEnB(waveEnB), .overflowFlag(overflowFlag),
    .compareFlagA(compareFlagA), .compareFlagB(compareFlagB));

  // a pin without waveform drive falls to its pull-down level
  tpw_load_model load (.clk(clk), .pinA(waveEnA & waveOutA), .pinB(waveEnB & waveOutB),
    .clr(clr), .hiA(hiA), .hiB(hiB));

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regRdEn <= 1'b0;
  endtask : rd

  // read data stands only in the cycle after the strobe, so compare there
  always @(posedge clk) begin
    rdPend <= regRdEn;
    if (rdPend) check({12'h0, regRdDataQ}, expQ.pop_front());
  end

  // stop first so the new compare values wait in the buffers
  task automatic cfg(input logic [2:0] wgm, input logic [1:0] cA, input logic [1:0] cB,
      input logic [7:0] vA, input logic [7:0] vB, input logic [2:0] cs);
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_CMP_A, vA);
    wr(ADDR_CMP_B, vB);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_A, {cA, cB, 2'b00, wgm[1:0]});
    wr(ADDR_CTRL_B, {4'h0, wgm[2], cs});
  endtask : cfg

  // warm-up covers the old top being reached once, so buffers are loaded
  task automatic measure(input int win, input logic [19:0] eA, input logic [19:0] eB,
      input logic enA, input logic enB);
    repeat (2 * win + 600) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (win) @(posedge clk);
    #1;
    check({19'h0, waveEnA}, {19'h0, enA});
    check({19'h0, waveEnB}, {19'h0, enB});
    check(hiA, eA);
    check(hiB, eB);
  endtask : measure

  // overflow and both compare flags must have fired during a full period
  task automatic flags();
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAGS, 8'h07);
    check({17'h0, compareFlagB, compareFlagA, overflowFlag}, 20'h7);
    wr(ADDR_FLAGS, 8'h07);
    rd(ADDR_FLAGS, 8'h00);
    check({17'h0, compareFlagB, compareFlagA, overflowFlag}, 20'h0);
  endtask : flags

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // hang guard, well past the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  // main sequence: boundaries first, then a random compare value per loop
  initial begin
    logic [7:0] r;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00);
    wr(ADDR_CMP_A, 8'h5a);
    rd(ADDR_CMP_A, 8'h5a);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      r = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
      cfg(WGM_FAST_FIXED, COM_NONINV, COM_INV, r, ~r, CS_DIV1);
      measure(256, {12'h0, r} + 20'h1, {12'h0, r}, 1'b1, 1'b1);
    end
    flags();
    $display("test fast fixed done");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      r = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
      cfg(WGM_PC_FIXED, COM_NONINV, COM_INV, r, r, CS_DIV1);
      measure(510, {11'h0, r, 1'b0}, 20'h1fe - {11'h0, r, 1'b0}, 1'b1, 1'b1);
    end
    flags();
    $display("test phase correct fixed done");
    cfg(WGM_FAST_VAR, COM_TOGGLE, COM_TOGGLE, 8'h09, 8'h04, CS_DIV1);
    measure(20, 20'ha, 20'h0, 1'b1, 1'b0);
    cfg(WGM_FAST_VAR, COM_INV, COM_NONINV, 8'h09, 8'h04, CS_DIV1);
    measure(10, 20'h0, 20'h5, 1'b1, 1'b1);
    cfg(WGM_PC_VAR, COM_NONINV, COM_NONINV, 8'h09, 8'h04, CS_DIV1);
    measure(18, 20'h12, 20'h8, 1'b1, 1'b1);
    cfg(WGM_PC_VAR, COM_TOGGLE, COM_OFF, 8'h09, 8'h04, CS_DIV1);
    measure(36, 20'h12, 20'h0, 1'b1, 1'b0);
    cfg(WGM_FAST_FIXED, COM_TOGGLE, COM_OFF, 8'h10, 8'h10, CS_DIV1);
    measure(256, 20'h0, 20'h0, 1'b0, 1'b0);
    $display("test variable top and toggle done");
    seed = xs(seed);
    r = seed[7:0];
    cfg(WGM_FAST_FIXED, COM_NONINV, COM_INV, r, ~r, CS_DIV8);
    measure(2048, ({12'h0, r} + 20'h1) << 3, {9'h0, r, 3'h0}, 1'b1, 1'b1);
    seed = xs(seed);
    r = seed[7:0];
    cfg(WGM_FAST_FIXED, COM_NONINV, COM_INV, r, ~r, CS_DIV64);
    measure(16384, ({12'h0, r} + 20'h1) << 6, {6'h0, r, 6'h0}, 1'b1, 1'b1);
    // slow selects: the count read just before the next tick is wait / n
    cfg(WGM_FAST_FIXED, COM_OFF, COM_OFF, 8'h80, 8'h80, CS_DIV256);
    repeat (1023) @(posedge clk);
    rd(ADDR_COUNT, 8'h03);
    cfg(WGM_FAST_FIXED, COM_OFF, COM_OFF, 8'h80, 8'h80, CS_DIV1024);
    repeat (2047) @(posedge clk);
    rd(ADDR_COUNT, 8'h01);
    $display("test prescaler done");
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule : tpw_timer_pwm_tb_top
`default_nettype wire
